// ===== cst_tile.sv
// Behavioural clock management tile: manager or reduced PLL variant.
// Assumes reference and feedback arrive as levels synchronous to clk_sys;
// generated clocks are modelled as levels stepped at clk_sys.
//
// Contract
// - Oscillator equals input times multiplier over divider
// - Output equals oscillator over its own divider
// - Settings map to multiplier, input and output divides
// - All output dividers share one oscillator
// - Eight outputs, some with inverted half-period copies
// - Feedback, and output zero on the manager, divide in eighths
// - Detector uses rising edges only
// - Down when fast, up when slow
// - Eight fixed phases plus one variable, selectable
// - Each input path has its own divider
// - Input muxes; transceiver clock reference only
// - Outputs zero to three cascade with phase offset
// - External spread spectrum passes when unused
// - PLL: outputs zero to five, no inversion, no shift
// - Advanced: second reference, select, stop flags
// - Unbounded fine shift, resolution follows oscillator
// - Fractional output has no programmable duty
`timescale 1ns/10ps
module cst_tile
    import cst_pkg::*;
#(
    parameter cst_variant_t VARIANT = CST_VAR_MANAGER,
    parameter int NOUT = CST_NUM_OUT,
    parameter int STOP_CYC = CST_STOP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Reference and feedback inputs
    input wire logic reference_input_primary,
    input wire logic reference_input_secondary,
    input wire logic reference_select,
    input wire logic [2:0] ref_source,
    input wire logic [2:0] fb_source,
    input wire logic feedback_input,
    input wire logic fb_internal,
    // Control
    input wire logic power_down_input,
    input wire logic manager_reset,
    input wire cst_core_cfg_t core_cfg,
    input wire logic [NOUT*CST_DIV_W-1:0] output_divide_setting,
    input wire logic [NOUT*CST_PH_W-1:0] phase_select,
    input wire logic [NOUT-1:0] duty_program,
    input wire logic [NOUT-1:0] fine_shift_use,
    input wire logic ss_internal_en,
    // Fine phase shift
    input wire logic phase_shift_enable,
    input wire logic phase_shift_direction,
    output logic phase_shift_done,
    // Generated clocks
    output logic [NOUT-1:0] generated_output,
    output logic [CST_NUM_INV-1:0] generated_output_inverted,
    output logic [CST_NUM_CASCADE-1:0] cascade_output,
    output logic feedback_output,
    output logic feedback_output_inverted,
    // Status
    output cst_status_t status
);
    // ====================================================================
    // Input selection
    logic ref_lvl, ref_lvl_q, fb_lvl, fb_lvl_q;
    logic ref_ok, fb_ok;
    logic fb_tick;

    always_comb begin
        // Transceiver clock is refused as feedback
        ref_ok = (ref_source <= CST_SRC_XCVR);
        fb_ok = (fb_source <= CST_SRC_FABRIC);
        // Second reference only on the advanced parts
        ref_lvl = (reference_select && VARIANT == CST_VAR_MANAGER) ?
            reference_input_secondary : reference_input_primary;
        ref_lvl = ref_lvl & ref_ok;
        // Internal feedback for synthesis only, else external return path
        fb_lvl = fb_internal ? fb_tick : (feedback_input & fb_ok);
    end

    // Rising edges only feed the detector
    logic ref_rise, fb_rise;
    assign ref_rise = ref_lvl & ~ref_lvl_q;
    assign fb_rise = fb_lvl & ~fb_lvl_q;

    // ====================================================================
    // Input dividers, one per path
    logic hold;
    logic ref_div_tick, fb_div_tick;
    assign hold = manager_reset | power_down_input;

    cst_divider u_ref_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_tick(ref_rise & ~hold),
        .divide({core_cfg.in_div, {CST_FRAC_BITS{1'b0}}}),
        .duty_half(1'b1),
        .tick(ref_div_tick),
        .level()
    );

    cst_divider u_fb_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_tick(fb_rise & ~hold),
        .divide({{CST_DIV_W-1{1'b0}}, 1'b1, {CST_FRAC_BITS{1'b0}}}),
        .duty_half(1'b1),
        .tick(fb_div_tick),
        .level()
    );

    // ====================================================================
    // Detector and oscillator rate
    logic pfd_up, pfd_down;

    cst_pfd u_pfd (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ref_rise(ref_div_tick),
        .fb_rise(fb_div_tick),
        .clear(hold),
        .up(pfd_up),
        .down(pfd_down)
    );

    // Oscillator modelled as a tick rate: ticks per divided reference
    // period settle to the multiplier, so rate = Fin * M / D.
    // Without internal spread the reference wander passes straight on.
    logic [CST_MULT_W-1:0] vco_acc_q, vco_acc_d;
    logic vco_tick;
    logic [CST_PH_W-1:0] vphase_q, vphase_d;
    logic [7:0] fixed_ph_q, fixed_ph_d;
    logic ps_done_q, ps_done_d;

    always_comb begin
        vco_acc_d = vco_acc_q;
        vco_tick = 1'b0;
        if (!hold) begin
            // Multiplier in eighths; each reference edge adds M ticks
            if (ref_div_tick) begin
                vco_acc_d = vco_acc_q + core_cfg.mult;
            end
            if (vco_acc_d >= CST_MULT_W'(8)) begin
                vco_acc_d = vco_acc_d - CST_MULT_W'(8);
                vco_tick = 1'b1;
            end
        end
        // Fixed phases are taps of the tick delayed by one to eight cycles
        fixed_ph_d = {fixed_ph_q[6:0], vco_tick};
        // Variable phase wraps freely in either direction
        vphase_d = vphase_q;
        ps_done_d = 1'b0;
        if (phase_shift_enable && VARIANT == CST_VAR_MANAGER) begin
            vphase_d = phase_shift_direction ? vphase_q + 4'h1 :
                vphase_q - 4'h1;
            ps_done_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vco_acc_q <= '0;
            fixed_ph_q <= 8'h00;
            vphase_q <= '0;
            ps_done_q <= 1'b0;
            ref_lvl_q <= 1'b0;
            fb_lvl_q <= 1'b0;
        end else begin
            vco_acc_q <= vco_acc_d;
            fixed_ph_q <= fixed_ph_d;
            vphase_q <= vphase_d;
            ps_done_q <= ps_done_d;
            ref_lvl_q <= ref_lvl;
            fb_lvl_q <= fb_lvl;
        end
    end

    // ====================================================================
    // Output dividers, all fed by the one oscillator
    logic [NOUT-1:0] out_lvl;
    logic [NOUT-1:0] out_src;
    logic fb_lvl_out;

    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : g_out
            logic [CST_PH_W-1:0] sel;
            logic [CST_MULT_W-1:0] dv;
            logic frac;
            always_comb begin
                sel = phase_select[g*CST_PH_W +: CST_PH_W];
                // Fine shift source only on the manager
                if (fine_shift_use[g] && VARIANT == CST_VAR_MANAGER) begin
                    out_src[g] =
                        fixed_ph_q[vphase_q[CST_PH_W-1:1]];
                end else if (sel < CST_PH_W'(8)) begin
                    out_src[g] = fixed_ph_q[sel[2:0]];
                end else begin
                    out_src[g] = vco_tick;
                end
                if (g == 0 && VARIANT == CST_VAR_MANAGER) begin
                    dv = core_cfg.out0_div;
                end else begin
                    dv = {output_divide_setting[g*CST_DIV_W +: CST_DIV_W],
                        {CST_FRAC_BITS{1'b0}}};
                end
                frac = (dv[CST_FRAC_BITS-1:0] != '0);
            end
            cst_divider u_odiv (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .src_tick(out_src[g]),
                .divide(dv),
                .duty_half(~duty_program[g] | frac),
                .tick(),
                .level(out_lvl[g])
            );
        end
    endgenerate

    // Feedback divider with fractional multiply
    cst_divider u_fbout (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src_tick(vco_tick),
        .divide(core_cfg.mult),
        .duty_half(1'b1),
        .tick(fb_tick),
        .level(fb_lvl_out)
    );

    // ====================================================================
    // Lock and stop detection
    logic [3:0] lock_cnt_q, lock_cnt_d;
    logic [1:0] fb_per_q, fb_per_d;
    logic locked_q, locked_d;
    logic [15:0] ref_idle_q, ref_idle_d, fb_idle_q, fb_idle_d;

    always_comb begin
        ref_idle_d = ref_rise ? '0 :
            (ref_idle_q == 16'(STOP_CYC) ? ref_idle_q : ref_idle_q + 16'h1);
        fb_idle_d = fb_rise ? '0 :
            (fb_idle_q == 16'(STOP_CYC) ? fb_idle_q : fb_idle_q + 16'h1);
        fb_per_d = (hold || ref_div_tick) ? 2'h0 :
            fb_per_q + 2'(fb_div_tick && fb_per_q != 2'h2);
        lock_cnt_d = lock_cnt_q;
        locked_d = locked_q;
        if (hold || ref_idle_q == 16'(STOP_CYC) ||
            (ref_div_tick && fb_per_q + 2'(fb_div_tick) != 2'h1)) begin
            lock_cnt_d = '0;
            locked_d = 1'b0;
        end else if (ref_div_tick) begin
            // One feedback edge per reference period counts as aligned
            if (lock_cnt_q == 4'(CST_LOCK_EDGES - 1)) begin
                locked_d = 1'b1;
            end else begin
                lock_cnt_d = lock_cnt_q + 4'h1;
            end
        end
    end

    // ====================================================================
    // Registered outputs
    cst_status_t status_d;
    logic [NOUT-1:0] gen_d;
    logic [CST_NUM_INV-1:0] inv_d;

    always_comb begin
        gen_d = out_lvl;
        inv_d = ~out_lvl[CST_NUM_INV-1:0];
        if (VARIANT == CST_VAR_PLL) begin
            // Reduced part: outputs six up and inversions absent
            for (int i = CST_NUM_PLL_OUT; i < NOUT; i++) begin
                gen_d[i] = 1'b0;
            end
            inv_d = '0;
        end
        if (hold) begin
            gen_d = '0;
            inv_d = '0;
        end
        status_d.locked = locked_d;
        status_d.ref_stopped = (ref_idle_d == 16'(STOP_CYC));
        status_d.fb_stopped = (fb_idle_d == 16'(STOP_CYC));
        status_d.pfd_up = pfd_up;
        status_d.pfd_down = pfd_down;
    end

    logic [NOUT-1:0] gen_q;
    logic [CST_NUM_INV-1:0] inv_q;
    logic fbo_q;
    cst_status_t status_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_q <= '0;
            fb_per_q <= '0;
            locked_q <= 1'b0;
            ref_idle_q <= '0;
            fb_idle_q <= '0;
            gen_q <= '0;
            inv_q <= '0;
            fbo_q <= 1'b0;
            status_q <= '0;
        end else begin
            lock_cnt_q <= lock_cnt_d;
            fb_per_q <= fb_per_d;
            locked_q <= locked_d;
            ref_idle_q <= ref_idle_d;
            fb_idle_q <= fb_idle_d;
            gen_q <= gen_d;
            inv_q <= inv_d;
            fbo_q <= fb_lvl_out & ~hold;
            status_q <= status_d;
        end
    end

    // Cascade taps are one register later, giving the stage offset
    logic [CST_NUM_CASCADE-1:0] casc_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            casc_q <= '0;
        end else begin
            casc_q <= gen_q[CST_NUM_CASCADE-1:0];
        end
    end

    assign generated_output = gen_q;
    assign generated_output_inverted = inv_q;
    assign cascade_output = casc_q;
    assign feedback_output = fbo_q;
    assign feedback_output_inverted = ~fbo_q & (VARIANT == CST_VAR_MANAGER);
    assign phase_shift_done = ps_done_q;
    assign status = status_q;
endmodule

// ===== cst_pkg.sv
// Package for the clock synthesis tile model: settings, flags, constants.
// Assumes a single 50 MHz system clock drives every model register.
package cst_pkg;

    // ====================================================================
    // Sizes
    localparam int CST_NUM_OUT = 8;
    localparam int CST_NUM_INV = 4;
    localparam int CST_NUM_CASCADE = 4;
    localparam int CST_NUM_PHASE = 9;
    localparam int CST_FRAC_BITS = 3;
    localparam int CST_DIV_W = 8;
    localparam int CST_MULT_W = CST_DIV_W + CST_FRAC_BITS;
    localparam int CST_PH_W = 4;
    localparam int CST_VAR_PHASE = 8;
    localparam int CST_NUM_PLL_OUT = 6;

    // ====================================================================
    // Reference source encoding
    localparam logic [2:0] CST_SRC_PIN = 3'h0;
    localparam logic [2:0] CST_SRC_GLOBAL = 3'h1;
    localparam logic [2:0] CST_SRC_REGIONAL = 3'h2;
    localparam logic [2:0] CST_SRC_HORIZ = 3'h3;
    localparam logic [2:0] CST_SRC_FABRIC = 3'h4;
    localparam logic [2:0] CST_SRC_XCVR = 3'h5;

    // ====================================================================
    // Reset values and timing
    localparam logic [CST_DIV_W-1:0] CST_DIV_RST = 8'h01;
    localparam logic [CST_MULT_W-1:0] CST_MULT_RST = 11'h008;
    localparam int CST_LOCK_EDGES = 8;
    localparam int CST_STOP_NS = 2000;
    localparam int CST_CLK_NS = 20;
    localparam int CST_STOP_CYC = CST_STOP_NS / CST_CLK_NS;

    // ====================================================================
    // Types
    typedef enum logic {CST_VAR_MANAGER, CST_VAR_PLL} cst_variant_t;

    typedef struct packed {
        logic [CST_MULT_W-1:0] mult;
        logic [CST_DIV_W-1:0] in_div;
        logic [CST_MULT_W-1:0] out0_div;
    } cst_core_cfg_t;

    typedef struct packed {
        logic locked;
        logic ref_stopped;
        logic fb_stopped;
        logic pfd_up;
        logic pfd_down;
    } cst_status_t;

endpackage

// ===== cst_divider.sv
// Counter divider with eighth-step fractional mode.
// Assumes the source enable marks one cycle per source clock period.
`timescale 1ns/10ps
module cst_divider
    import cst_pkg::*;
#(
    parameter int DIV_W = CST_DIV_W,
    parameter int FRAC = CST_FRAC_BITS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic src_tick,
    input wire logic [DIV_W+FRAC-1:0] divide,
    input wire logic duty_half,
    // Output
    output logic tick,
    output logic level
);
    // ====================================================================
    // Accumulator in eighths; period alternates to average the fraction
    localparam int AW = DIV_W + FRAC + 1;
    logic [AW-1:0] acc_q, acc_d;
    logic tick_q, tick_d;
    logic lvl_q, lvl_d;
    logic [AW-1:0] step;
    logic [AW-1:0] div_ext;

    always_comb begin
        step = AW'(1) << FRAC;
        div_ext = (divide == '0) ? step : {1'b0, divide};
        acc_d = acc_q;
        tick_d = 1'b0;
        lvl_d = lvl_q;
        if (src_tick) begin
            if (acc_q + step >= div_ext) begin
                acc_d = acc_q + step - div_ext;
                tick_d = 1'b1;
                lvl_d = 1'b1;
            end else begin
                acc_d = acc_q + step;
                // Fixed half duty unless a programmed duty is allowed
                if (duty_half && (acc_d >= (div_ext >> 1))) begin
                    lvl_d = 1'b0;
                end
                if (!duty_half) begin
                    lvl_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            tick_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
            lvl_q <= lvl_d;
        end
    end

    assign tick = tick_q;
    assign level = lvl_q;
endmodule

// ===== cst_pfd.sv
// Phase-frequency detector on rising edges of two enable strobes.
// Assumes each strobe is one cycle per divided clock period.
`timescale 1ns/10ps
module cst_pfd
    import cst_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Compared edges
    input wire logic ref_rise,
    input wire logic fb_rise,
    input wire logic clear,
    // Result
    output logic up,
    output logic down
);
    // ====================================================================
    // Classic two-flop detector; both set resets both
    logic up_q, up_d;
    logic dn_q, dn_d;

    always_comb begin
        up_d = up_q | ref_rise;
        dn_d = dn_q | fb_rise;
        if ((up_d && dn_d) || clear) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_d;
            dn_q <= dn_d;
        end
    end

    assign up = up_q;
    assign down = dn_q;
endmodule

// ===== cst_tile_sva.sv
// Checker for the clock synthesis tile: hold, pairing, shift handshake.
// Assumes it is bound to cst_tile with the same NOUT.
`timescale 1ns/10ps
module cst_tile_sva
    import cst_pkg::*;
#(
    parameter int NOUT = CST_NUM_OUT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Controls
    input wire logic power_down_input,
    input wire logic manager_reset,
    input wire logic phase_shift_enable,
    // Observed
    input wire logic phase_shift_done,
    input wire logic [NOUT-1:0] generated_output,
    input wire logic [CST_NUM_INV-1:0] generated_output_inverted,
    input wire logic [CST_NUM_CASCADE-1:0] cascade_output,
    input wire logic feedback_output,
    input wire logic feedback_output_inverted,
    input wire cst_status_t status
);
    // ====================================================================
    // Helpers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic hold;
    assign hold = power_down_input | manager_reset;
    // Outputs lag the hold by up to two cycles, so wait three
    sequence s_run;
        !hold [*3];
    endsequence
    sequence s_held;
        hold [*2];
    endsequence

    // ====================================================================
    // Properties
    a_hold_lock_low: assert property (hold |=> !status.locked)
        else $error("lock indicator high while held");
    a_hold_outs_low: assert property (
        s_held |-> generated_output == '0)
        else $error("output clock toggling while held");
    a_inv_out_pair: assert property (s_run |->
        generated_output_inverted == ~generated_output[CST_NUM_INV-1:0])
        else $error("inverted output not complement");
    a_fb_inv_pair: assert property (s_run |->
        feedback_output_inverted == ~feedback_output)
        else $error("inverted feedback not complement");
    a_cascade_lag: assert property (s_run |->
        cascade_output == $past(generated_output[CST_NUM_CASCADE-1:0]))
        else $error("cascade output not one cycle behind");
    a_shift_done: assert property (
        phase_shift_enable && !hold |=> phase_shift_done)
        else $error("shift step not acknowledged");
    a_done_cause: assert property (
        phase_shift_done |-> $past(phase_shift_enable))
        else $error("shift done without a step");
    a_stop_unlock: assert property (
        $rose(status.ref_stopped) |-> ##[0:2] !status.locked)
        else $error("lock held after reference stopped");
    c_locked: cover property ($rose(status.locked));
endmodule

// ===== cst_ref_source.sv
// Reference clock source and global buffer feedback return for the tile.
// Assumes clk_sys paces both references; half periods are powers of two.
`timescale 1ns/10ps
module cst_ref_source #(
    parameter int PRI_BIT = 5,
    parameter int SEC_BIT = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Feedback loop
    input wire logic feedback_output,
    output logic feedback_input,
    // References
    output logic reference_input_primary,
    output logic reference_input_secondary
);
    // ====================================================================
    // Counter and return path
    logic [15:0] cnt_q, cnt_d;
    logic fb_q, fb_d;
    always_comb begin
        cnt_d = cnt_q + 16'h0001;
        fb_d = feedback_output;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            fb_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fb_q <= fb_d;
        end
    end
    // Equal high and low widths keep the pulse minimum met
    assign reference_input_primary = cnt_q[PRI_BIT];
    assign reference_input_secondary = cnt_q[SEC_BIT];
    assign feedback_input = fb_q;
endmodule

// ===== tb.sv
// Testbench for the clock synthesis tile, manager variant.
// Assumes cst_pkg, cst_tile, its checker and the source model compiled.
`timescale 1ns/10ps
module tb
    import cst_pkg::*;
;
    // ====================================================================
    // Signals
    logic clk_sys, rst_n, ref_sel, fb_int, pd, mrst, ss_en, ps_en, ps_dir;
    logic [2:0] ref_src, fb_src;
    cst_core_cfg_t cfg;
    logic [63:0] odiv;
    logic [31:0] phs;
    logic [7:0] duty, fine, gen, prev;
    logic [3:0] ginv, casc;
    logic fbo, fbob, ps_done, ref1, ref2, fbi;
    cst_status_t st;
    int n_mismatch, comparisons, cyc, cnt[8];

    cst_ref_source u_src (.clk_sys(clk_sys), .rst_n(rst_n),
        .feedback_output(fbo), .feedback_input(fbi),
        .reference_input_primary(ref1), .reference_input_secondary(ref2));
    // Default stop window must stay above the longest reference period
    cst_tile u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reference_input_primary(ref1), .reference_input_secondary(ref2),
        .reference_select(ref_sel), .ref_source(ref_src),
        .fb_source(fb_src), .feedback_input(fbi), .fb_internal(fb_int),
        .power_down_input(pd), .manager_reset(mrst), .core_cfg(cfg),
        .output_divide_setting(odiv), .phase_select(phs),
        .duty_program(duty), .fine_shift_use(fine), .ss_internal_en(ss_en),
        .phase_shift_enable(ps_en), .phase_shift_direction(ps_dir),
        .phase_shift_done(ps_done), .generated_output(gen),
        .generated_output_inverted(ginv), .cascade_output(casc),
        .feedback_output(fbo), .feedback_output_inverted(fbob),
        .status(st));

    // ====================================================================
    // Clock, timeout, tasks
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 50000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_rng(int got, int exp, int tol);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic check(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic measure(int w);
        for (int i = 0; i < 8; i++) cnt[i] = 0;
        prev = gen;
        repeat (w) begin
            @(posedge clk_sys);
            for (int i = 0; i < 8; i++) cnt[i] += gen[i] & ~prev[i];
            prev = gen;
        end
    endtask
    task automatic wait_lock();
        int k;
        k = 0;
        while (st.locked !== 1'b1 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        check(st.locked, 1'b1);
    endtask
    task automatic setup(int m8, int d, int o0);
        @(posedge clk_sys);
        cfg <= '{mult: m8[10:0], in_div: d[7:0], out0_div: o0[10:0]};
        repeat (300) @(posedge clk_sys);
    endtask
    // Expected rising edges: reference periods times M over D times O
    task automatic check_all(int nref, int m8, int d, int o0);
        check_rng(cnt[0], nref * m8 / (d * o0), 3);
        for (int i = 1; i < 8; i++) begin
            check_rng(cnt[i], nref * m8 / (d * (i + 2) * 8), 3);
        end
    endtask

    // ====================================================================
    // Scenarios
    initial begin
        rst_n = 1'b0;
        {ref_sel, pd, mrst, ss_en, ps_en, ps_dir} = 6'h00;
        fb_int = 1'b1;
        ref_src = CST_SRC_PIN;
        fb_src = CST_SRC_GLOBAL;
        cfg = '{mult: 11'h040, in_div: 8'h01, out0_div: 11'h010};
        for (int i = 0; i < 8; i++) odiv[i*8 +: 8] = 8'(i + 2);
        phs = '0;
        duty = 8'h00;
        fine = 8'h00;
        repeat (20) @(posedge clk_sys);
        check(gen, 8'h00);
        check(fbob, 1'b1);
        rst_n <= 1'b1;
        wait_lock();
        measure(2048);
        check_all(32, 64, 1, 16);
        setup(64, 2, 16);
        wait_lock();
        measure(2048);
        check_all(32, 64, 2, 16);
        duty <= 8'hFF;
        setup(68, 1, 20);
        measure(2048);
        check_all(32, 68, 1, 20);
        duty <= 8'h00;
        ss_en <= 1'b1;
        ref_sel <= 1'b1;
        setup(64, 1, 16);
        measure(2048);
        check_all(64, 64, 1, 16);
        ref_sel <= 1'b0;
        setup(64, 1, 16);
        for (int s = 0; s < 6; s++) begin
            ref_src <= s[2:0];
            measure(512);
            check_rng(cnt[1], 64 / 3, 3);
        end
        ref_src <= 3'h6;
        repeat (150) @(posedge clk_sys);
        check(st.ref_stopped, 1'b1);
        check(st.locked, 1'b0);
        measure(256);
        check(cnt[1], 0);
        ref_src <= CST_SRC_XCVR;
        fb_int <= 1'b0;
        fb_src <= CST_SRC_XCVR;
        repeat (2000) @(posedge clk_sys);
        check(st.locked, 1'b0);
        check(st.fb_stopped, 1'b1);
        check({st.pfd_up, st.pfd_down}, 2'h2);
        fb_int <= 1'b1;
        fb_src <= CST_SRC_GLOBAL;
        wait_lock();
        fine <= 8'h01;
        for (int p = 0; p < 9; p++) begin
            phs[11:8] <= p[3:0];
            measure(512);
            check_rng(cnt[2], 16, 2);
        end
        // Back-to-back steps, both directions
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            ps_en <= 1'b1;
            ps_dir <= k[0];
            #1 if (k > 0) check(ps_done, 1'b1);
        end
        @(posedge clk_sys);
        ps_en <= 1'b0;
        #1 check(ps_done, 1'b1);
        @(posedge clk_sys);
        #1 check(ps_done, 1'b0);
        @(posedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            pd <= (k == 0);
            mrst <= (k == 1);
            repeat (3) @(posedge clk_sys);
            check({st.locked, st.pfd_up, st.pfd_down, gen}, 11'h000);
            measure(256);
            check(cnt[1] + cnt[2], 0);
            pd <= 1'b0;
            mrst <= 1'b0;
            wait_lock();
        end
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({st.locked, gen}, 9'h000);
        rst_n <= 1'b1;
        wait_lock();
        print_verdict();
    end
endmodule

bind cst_tile cst_tile_sva #(.NOUT(NOUT)) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .power_down_input(power_down_input), .manager_reset(manager_reset),
    .phase_shift_enable(phase_shift_enable),
    .phase_shift_done(phase_shift_done),
    .generated_output(generated_output),
    .generated_output_inverted(generated_output_inverted),
    .cascade_output(cascade_output), .feedback_output(feedback_output),
    .feedback_output_inverted(feedback_output_inverted), .status(status));
